// *** pkg/ssd_pkg.sv ***
// Purpose: constants and types shared by the shift/square datapath
// Assumes: 40-bit accumulators, 16-bit auxiliary/temporary registers
// Notes: operation codes are local to this datapath
package ssd_pkg;
   localparam int SSD_ACC_W = 40;
   localparam int SSD_WORD_W = 16;
   localparam int SSD_PROD_W = 32;
   localparam int SSD_MUL_IN_W = 17;
   // accumulator saturation values, narrow and wide overflow ranges
   localparam logic [39:0] SSD_SAT32_POS = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SSD_SAT32_NEG = 40'hFF_8000_0000;
   localparam logic [39:0] SSD_SAT40_POS = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] SSD_SAT40_NEG = 40'h80_0000_0000;
   // 16-bit register saturation values
   localparam logic [15:0] SSD_SAT16_POS = 16'h7FFF;
   localparam logic [15:0] SSD_SAT16_NEG = 16'h8000;
   // rounding constant added at bit 15 of the accumulator
   localparam logic [39:0] SSD_ROUND_ADD = 40'h00_0000_8000;
   localparam logic [39:0] SSD_ROUND_MASK = 40'hFF_FFFF_0000;
   localparam logic [39:0] SSD_ACC_RESET = 40'h00_0000_0000;
   localparam logic [15:0] SSD_WORD_RESET = 16'h0000;
   typedef enum logic [2:0] {
      SSD_OP_NONE,
      SSD_OP_SHIFT_RIGHT,
      SSD_OP_SHIFT_LEFT,
      SSD_OP_SQA_REG,
      SSD_OP_SQA_MEM,
      SSD_OP_SQUARE_DISTANCE
   } ssd_op_t;
endpackage

// *** core/ssd_square_mac.sv ***
// Purpose: squaring multiplier with fractional shift and saturation
// Assumes: operand is already a 17-bit signed multiplier input
// Notes: purely combinational; the caller accumulates and registers
`timescale 1ns/10ps
module ssd_square_mac
   import ssd_pkg::*;
(
   input wire logic [16:0] mul_in,
   input wire logic fractional_mode,
   input wire logic multiply_saturate_mode,
   output logic [39:0] product_ext
);
   logic signed [33:0] raw_prod;
   logic [33:0] shifted_prod;
   logic [31:0] prod32;

   ////////////////////////////////////////////////////////////////////
   // square, optional fractional doubling, 32-bit limit, sign extend
   always_comb begin
      raw_prod = $signed(mul_in) * $signed(mul_in);
      // fractional doubling before any other use
      shifted_prod = fractional_mode ? {raw_prod[32:0], 1'b0}
                                     : raw_prod;
      // of sign-extended 16-bit operands only 8000h squared in fractional mode reaches 2^31; a saturating
      // multiply clamps it, otherwise the top bits wrap
      if (multiply_saturate_mode && fractional_mode &&
          shifted_prod[33:31] != 3'b000) begin
         prod32 = 32'h7FFF_FFFF;
      end else begin
         prod32 = shifted_prod[31:0];
      end
      product_ext = {{8{prod32[31]}}, prod32};
   end
endmodule

// *** core/ssd_datapath.sv ***
// Purpose: one-bit signed shifts, square-accumulate, square distance
// Assumes: decode presents one operation per cycle with its operands
// Notes: results and flags are registered on the edge after op_valid
`timescale 1ns/10ps
module ssd_datapath
   import ssd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic op_valid,
   input wire ssd_op_t op_code,
   input wire logic shift_is_accum,
   input wire logic round_enable,
   input wire logic copy_to_temp3,
   input wire logic [39:0] source_accumulator,
   input wire logic [39:0] dest_accumulator,
   input wire logic [15:0] aux_or_temp_register,
   input wire logic [15:0] mem_operand_x,
   input wire logic [15:0] mem_operand_y,
   input wire logic sign_extend_mode,
   input wire logic wide_overflow_mode,
   input wire logic accum_saturate_enable,
   input wire logic addr_unit_saturate_enable,
   input wire logic legacy_compat_mode,
   input wire logic fractional_mode,
   input wire logic multiply_saturate_mode,
   input wire logic rounding_mode,
   output logic [39:0] acc_result_reg,
   output logic acc_result_we_reg,
   output logic [39:0] acc_second_result_reg,
   output logic acc_second_we_reg,
   output logic [15:0] word_result_reg,
   output logic word_result_we_reg,
   output logic [15:0] temp_register_three_reg,
   output logic temp3_we_reg,
   output logic dst_accum_overflow_flag_reg,
   output logic src_accum_overflow_flag_reg,
   output logic carry_flag_reg,
   output logic carry_we_reg
);
   logic eff_wide;
   logic [16:0] mul_in;
   logic [39:0] product_ext;
   logic [39:0] acc_next;
   logic acc_we_next;
   logic [39:0] acc2_next;
   logic acc2_we_next;
   logic [15:0] word_next;
   logic word_we_next;
   logic dst_ov_next;
   logic src_ov_next;
   logic carry_next;
   logic carry_we_next;
   logic [39:0] sh_in;
   logic [39:0] sh_out;
   logic sh_ov;
   logic [15:0] w_out;
   logic [39:0] sum_w;
   logic [39:0] sum_r;
   logic add_ov;
   logic [40:0] diff_full;
   logic [39:0] dx;
   logic [39:0] dy;
   logic dif_ov;

   // legacy mode behaves as wide overflow mode for shifts
   assign eff_wide = wide_overflow_mode | legacy_compat_mode;

   ////////////////////////////////////////////////////////////////////
   // multiplier input select: accumulator slice or sign-extended word
   always_comb begin
      if (op_code == SSD_OP_SQA_MEM) begin
         mul_in = {mem_operand_x[15], mem_operand_x};
      end else begin
         mul_in = source_accumulator[32:16];
      end
   end

   ssd_square_mac u_square (
      .mul_in(mul_in),
      .fractional_mode(fractional_mode),
      .multiply_saturate_mode(multiply_saturate_mode),
      .product_ext(product_ext)
   );

   ////////////////////////////////////////////////////////////////////
   // accumulator shifter: guard bits replaced when narrow mode
   always_comb begin
      sh_in = source_accumulator;
      if (!eff_wide) begin
         sh_in[39:32] = sign_extend_mode ? {8{source_accumulator[31]}}
                                         : 8'h00;
      end
      sh_out = 40'h00_0000_0000;
      sh_ov = 1'b0;
      if (op_code == SSD_OP_SHIFT_RIGHT) begin
         // bit 39 extended by sign mode; bit 0 falls out
         sh_out = {sign_extend_mode & sh_in[39],
                   sh_in[39:1]};
      end else begin
         sh_out = {sh_in[38:0], 1'b0};
         if (eff_wide) begin
            sh_ov = sh_in[39] ^ sh_in[38];
         end else begin
            // the doubled value must still fit in 32 signed bits; the
            // guard bits alone agree with bit 31 when sign_extend_mode extends them
            sh_ov = (sh_in[39:30] != {10{sh_in[30]}});
         end
         // legacy mode suppresses detection, report and saturation
         if (legacy_compat_mode) begin
            sh_ov = 1'b0;
         end
         if (sh_ov && accum_saturate_enable) begin
            if (eff_wide) begin
               sh_out = sh_in[39] ? SSD_SAT40_NEG : SSD_SAT40_POS;
            end else begin
               sh_out = sh_in[39] ? SSD_SAT32_NEG : SSD_SAT32_POS;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 16-bit address-unit shift of auxiliary or temporary register
   always_comb begin
      if (op_code == SSD_OP_SHIFT_RIGHT) begin
         w_out = {aux_or_temp_register[15],
                  aux_or_temp_register[15:1]};
      end else if (addr_unit_saturate_enable &&
                   (aux_or_temp_register[15] ^ aux_or_temp_register[14])) begin
         w_out = aux_or_temp_register[15] ? SSD_SAT16_NEG
                                          : SSD_SAT16_POS;
      end else begin
         w_out = {aux_or_temp_register[14:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // accumulate: square plus selected accumulator, round, saturate
   always_comb begin
      // memory and distance forms add to source/dest as documented
      if (op_code == SSD_OP_SQA_MEM) begin
         sum_w = source_accumulator + product_ext;
      end else begin
         sum_w = dest_accumulator + product_ext;
      end
      // rounding only on the register and memory forms
      sum_r = sum_w;
      if (round_enable && op_code != SSD_OP_SQUARE_DISTANCE) begin
         sum_r = rounding_mode ? sum_w
                               : sum_w + SSD_ROUND_ADD;
         sum_r = sum_r & SSD_ROUND_MASK;
      end
      if (wide_overflow_mode) begin
         add_ov = (sum_r[39] != sum_w[39]) ||
                  ((op_code == SSD_OP_SQA_MEM ? source_accumulator[39]
                    : dest_accumulator[39]) == product_ext[39] &&
                   sum_w[39] != product_ext[39]);
      end else begin
         add_ov = (sum_r[39:31] != {9{sum_r[31]}});
      end
      if (add_ov && accum_saturate_enable) begin
         if (wide_overflow_mode) begin
            sum_r = sum_r[39] ? SSD_SAT40_NEG : SSD_SAT40_POS;
         end else begin
            sum_r = sum_r[39] ? SSD_SAT32_NEG : SSD_SAT32_POS;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // distance subtraction: (x << 16) - (y << 16) on 40 bits
   always_comb begin
      // guard bits carry sign only when sign extension is on
      dx = {(sign_extend_mode ? {8{mem_operand_x[15]}} : 8'h00),
            mem_operand_x, 16'h0000};
      dy = {(sign_extend_mode ? {8{mem_operand_y[15]}} : 8'h00),
            mem_operand_y, 16'h0000};
      diff_full = {1'b0, dx} - {1'b0, dy};
      if (eff_wide) begin
         dif_ov = (dx[39] != dy[39]) &&
                  (diff_full[39] != dx[39]);
      end else begin
         dif_ov = (diff_full[39:31] != {9{diff_full[31]}});
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next-state selection per operation
   always_comb begin
      acc_next = acc_result_reg;
      acc_we_next = 1'b0;
      acc2_next = acc_second_result_reg;
      acc2_we_next = 1'b0;
      word_next = word_result_reg;
      word_we_next = 1'b0;
      dst_ov_next = 1'b0;
      src_ov_next = 1'b0;
      carry_next = carry_flag_reg;
      carry_we_next = 1'b0;
      if (op_valid) begin
         unique case (op_code)
            SSD_OP_SHIFT_RIGHT, SSD_OP_SHIFT_LEFT: begin
               if (shift_is_accum) begin
                  acc_next = sh_out;
                  acc_we_next = 1'b1;
                  dst_ov_next = sh_ov;
               end else begin
                  word_next = w_out;
                  word_we_next = 1'b1;
                  src_ov_next = (op_code == SSD_OP_SHIFT_LEFT) &&
                     (aux_or_temp_register[15] ^
                      aux_or_temp_register[14]);
               end
            end
            SSD_OP_SQA_REG, SSD_OP_SQA_MEM: begin
               acc_next = sum_r;
               acc_we_next = 1'b1;
               dst_ov_next = add_ov;
            end
            SSD_OP_SQUARE_DISTANCE: begin
               acc_next = sum_r;
               acc_we_next = 1'b1;
               dst_ov_next = add_ov;
               acc2_next = (dif_ov && accum_saturate_enable) ?
                  (diff_full[39] ^ dif_ov ^ 1'b1 ? SSD_SAT40_POS :
                   SSD_SAT40_NEG) : diff_full[39:0];
               if (dif_ov && accum_saturate_enable && !eff_wide) begin
                  // the 40-bit difference is exact in narrow mode, so
                  // its sign gives the overflow direction
                  acc2_next = diff_full[39] ? SSD_SAT32_NEG
                                            : SSD_SAT32_POS;
               end
               acc2_we_next = 1'b1;
               src_ov_next = dif_ov;
               // no borrow shows as carry set
               carry_next = ~diff_full[40];
               carry_we_next = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // results and write strobes, one cycle after the request
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         acc_result_reg <= SSD_ACC_RESET;
         acc_result_we_reg <= 1'b0;
         acc_second_result_reg <= SSD_ACC_RESET;
         acc_second_we_reg <= 1'b0;
         word_result_reg <= SSD_WORD_RESET;
         word_result_we_reg <= 1'b0;
      end else begin
         acc_result_reg <= acc_next;
         acc_result_we_reg <= acc_we_next;
         acc_second_result_reg <= acc2_next;
         acc_second_we_reg <= acc2_we_next;
         word_result_reg <= word_next;
         word_result_we_reg <= word_we_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // temporary register three copy on the memory square form
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         temp_register_three_reg <= SSD_WORD_RESET;
         temp3_we_reg <= 1'b0;
      end else begin
         temp3_we_reg <= op_valid && op_code == SSD_OP_SQA_MEM &&
                         copy_to_temp3;
         if (op_valid && op_code == SSD_OP_SQA_MEM && copy_to_temp3) begin
            temp_register_three_reg <= mem_operand_x;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status flags: overflow flags are set-only pulses to the core,
   // carry holds its value until the next distance operation
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dst_accum_overflow_flag_reg <= 1'b0;
         src_accum_overflow_flag_reg <= 1'b0;
         carry_flag_reg <= 1'b0;
         carry_we_reg <= 1'b0;
      end else begin
         dst_accum_overflow_flag_reg <= dst_ov_next;
         src_accum_overflow_flag_reg <= src_ov_next;
         carry_flag_reg <= carry_next;
         carry_we_reg <= carry_we_next;
      end
   end
endmodule

// *** test/ssd_datapath_chk.sv ***
// Purpose: port-level timing and value checks for ssd_datapath
// Assumes: each accepted request answers on the next rising edge
// Notes: sees only the datapath ports; bound below
`timescale 1ns/10ps
module ssd_datapath_chk
   import ssd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic op_valid,
   input wire ssd_op_t op_code,
   input wire logic shift_is_accum,
   input wire logic round_enable,
   input wire logic copy_to_temp3,
   input wire logic [39:0] source_accumulator,
   input wire logic [39:0] dest_accumulator,
   input wire logic [15:0] aux_or_temp_register,
   input wire logic [15:0] mem_operand_x,
   input wire logic [15:0] mem_operand_y,
   input wire logic sign_extend_mode,
   input wire logic wide_overflow_mode,
   input wire logic accum_saturate_enable,
   input wire logic addr_unit_saturate_enable,
   input wire logic legacy_compat_mode,
   input wire logic fractional_mode,
   input wire logic multiply_saturate_mode,
   input wire logic rounding_mode,
   input wire logic [39:0] acc_result_reg,
   input wire logic acc_result_we_reg,
   input wire logic [39:0] acc_second_result_reg,
   input wire logic acc_second_we_reg,
   input wire logic [15:0] word_result_reg,
   input wire logic word_result_we_reg,
   input wire logic [15:0] temp_register_three_reg,
   input wire logic temp3_we_reg,
   input wire logic dst_accum_overflow_flag_reg,
   input wire logic src_accum_overflow_flag_reg,
   input wire logic carry_flag_reg,
   input wire logic carry_we_reg
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic sr;
   logic sl;
   logic [15:0] ax;
   logic [39:0] sa;
   ////////////////////////////////////////////////////////////////////////
   // request shorthands; shift requests split by direction
   assign sr = op_valid && op_code == SSD_OP_SHIFT_RIGHT;
   assign sl = op_valid && op_code == SSD_OP_SHIFT_LEFT;
   assign ax = aux_or_temp_register;
   assign sa = source_accumulator;
   sequence s_dist_req;
      op_valid && op_code == SSD_OP_SQUARE_DISTANCE;
   endsequence
   sequence s_dist_done;
      acc_result_we_reg && acc_second_we_reg && carry_we_reg;
   endsequence
   property p_dist; s_dist_req |=> s_dist_done; endproperty
   property p_idle; !op_valid |=> !(acc_result_we_reg || word_result_we_reg
      || acc_second_we_reg || temp3_we_reg); endproperty
   property p_racc; sr && shift_is_accum && wide_overflow_mode |=>
      acc_result_we_reg && acc_result_reg ==
      {$past(sign_extend_mode & sa[39]), $past(sa[39:1])}; endproperty
   property p_rreg; sr && !shift_is_accum |=> word_result_we_reg &&
      word_result_reg == {$past(ax[15]), $past(ax[15:1])}; endproperty
   property p_lreg; sl && !shift_is_accum && !addr_unit_saturate_enable
      |=> word_result_reg == {$past(ax[14:0]), 1'b0}; endproperty
   property p_lreg_ovf; sl && !shift_is_accum |=>
      src_accum_overflow_flag_reg == $past(ax[15] ^ ax[14]); endproperty
   property p_lreg_sat; sl && !shift_is_accum && addr_unit_saturate_enable
      && ax[15] != ax[14] |=> word_result_reg ==
      ($past(ax[15]) ? SSD_SAT16_NEG : SSD_SAT16_POS); endproperty
   property p_legacy; sl && shift_is_accum && legacy_compat_mode |=>
      !dst_accum_overflow_flag_reg &&
      acc_result_reg == {$past(sa[38:0]), 1'b0}; endproperty
   property p_wide_ovf; sl && shift_is_accum && wide_overflow_mode &&
      !legacy_compat_mode |=>
      dst_accum_overflow_flag_reg == $past(sa[39] ^ sa[38]); endproperty
   property p_temp3; op_valid && op_code == SSD_OP_SQA_MEM && copy_to_temp3
      |=> temp3_we_reg && temp_register_three_reg == $past(mem_operand_x);
   endproperty
   a_dist: assert property (p_dist) else $error("distance strobes");
   a_idle: assert property (p_idle) else $error("idle strobe");
   a_racc: assert property (p_racc) else $error("acc right");
   a_rreg: assert property (p_rreg) else $error("reg right");
   a_lreg: assert property (p_lreg) else $error("reg left");
   a_lreg_ovf: assert property (p_lreg_ovf) else $error("reg ovf");
   a_lreg_sat: assert property (p_lreg_sat) else $error("reg sat");
   a_legacy: assert property (p_legacy) else $error("legacy");
   a_wide_ovf: assert property (p_wide_ovf) else $error("wide ovf");
   a_temp3: assert property (p_temp3) else $error("temp3 copy");
endmodule
////////////////////////////////////////////////////////////////////////////
bind ssd_datapath ssd_datapath_chk u_chk (.*);

// *** test/ssd_decode_model.sv ***
// Purpose: decode and operand fetch stand-in driving the datapath
// Assumes: one request per falling edge, held across the rising edge
// Notes: released accumulator and aux lines show inverted data; memory operands keep old values
`timescale 1ns/10ps
module ssd_decode_model
   import ssd_pkg::*;
(
   input wire logic ref_clk,
   output logic op_valid,
   output ssd_op_t op_code,
   output logic shift_is_accum,
   output logic round_enable,
   output logic copy_to_temp3,
   output logic [39:0] source_accumulator,
   output logic [39:0] dest_accumulator,
   output logic [15:0] aux_or_temp_register,
   output logic [15:0] mem_operand_x,
   output logic [15:0] mem_operand_y,
   output logic sign_extend_mode,
   output logic wide_overflow_mode,
   output logic accum_saturate_enable,
   output logic addr_unit_saturate_enable,
   output logic legacy_compat_mode,
   output logic fractional_mode,
   output logic multiply_saturate_mode,
   output logic rounding_mode
);
   logic [7:0] mode_bits = 8'h00;
   logic [2:0] flag_bits = 3'h0;
   // status bits travel as one vector to keep the tasks short
   assign {sign_extend_mode, wide_overflow_mode, accum_saturate_enable,
      addr_unit_saturate_enable, legacy_compat_mode, fractional_mode,
      multiply_saturate_mode, rounding_mode} = mode_bits;
   assign {shift_is_accum, round_enable, copy_to_temp3} = flag_bits;
   initial begin
      op_valid = 1'b0;
      op_code = SSD_OP_NONE;
      {source_accumulator, dest_accumulator} = '0;
      {aux_or_temp_register, mem_operand_x, mem_operand_y} = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one request, left standing until the next call overwrites it
   task issue(input ssd_op_t op, input logic [2:0] f, input logic [7:0] m,
      input logic [39:0] s, d, input logic [15:0] a, x, y);
      @(negedge ref_clk);
      op_valid = 1'b1;
      op_code = op;
      flag_bits = f;
      mode_bits = m;
      {source_accumulator, dest_accumulator} = {s, d};
      {aux_or_temp_register, mem_operand_x, mem_operand_y} = {a, x, y};
   endtask
   // release: accumulator and aux operands flip; memory operands keep old data
   task idle;
      @(negedge ref_clk);
      op_valid = 1'b0;
      op_code = SSD_OP_NONE;
      source_accumulator = ~source_accumulator;
      dest_accumulator = ~dest_accumulator;
      aux_or_temp_register = ~aux_or_temp_register;
   endtask
endmodule

// *** test/test_ssd_datapath.sv ***
// Purpose: self-checking bench for ssd_datapath
// Assumes: results appear one edge after each request
// Notes: expectations queue per output group, watcher pops in order
`timescale 1ns/10ps
module test_ssd_datapath
   import ssd_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic op_valid, shift_is_accum, round_enable, copy_to_temp3;
   ssd_op_t op_code;
   logic [39:0] source_accumulator, dest_accumulator;
   logic [39:0] acc_result_reg, acc_second_result_reg, s;
   logic [15:0] aux_or_temp_register, mem_operand_x, mem_operand_y, a;
   logic [15:0] word_result_reg, temp_register_three_reg;
   logic sign_extend_mode, wide_overflow_mode, accum_saturate_enable;
   logic addr_unit_saturate_enable, legacy_compat_mode, fractional_mode;
   logic multiply_saturate_mode, rounding_mode, acc_result_we_reg;
   logic acc_second_we_reg, word_result_we_reg, temp3_we_reg;
   logic dst_accum_overflow_flag_reg, src_accum_overflow_flag_reg;
   logic carry_flag_reg, carry_we_reg;
   logic [7:0] m;
   logic [31:0] rng = 32'hD4E08507;
   logic [40:0] acc_q[$], word_q[$], sec_q[$], t3_q[$];
   int bad_count = 0;
   int comparisons = 0;
   ssd_decode_model u_dec (.*);
   ssd_datapath u_dut (.*);
   always #25 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task chk(input logic [40:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("mismatches %0d of %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one request; shifts of a 16-bit register answer on the word port
   task t(input ssd_op_t op, input logic [2:0] f, input logic [7:0] m,
      input logic [39:0] s, d, input logic [15:0] a, x,
      input logic [40:0] e);
      u_dec.issue(op, f, m, s, d, a, x, '0);
      if (op inside {SSD_OP_SHIFT_LEFT, SSD_OP_SHIFT_RIGHT} && !f[2])
         word_q.push_back(e);
      else
         acc_q.push_back(e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watcher: an empty queue yields x, which can never match
   always @(negedge ref_clk) begin
      if (acc_result_we_reg === 1'b1)
         chk({dst_accum_overflow_flag_reg, acc_result_reg},
            acc_q.size() > 0 ? acc_q.pop_front() : 'x);
      if (word_result_we_reg === 1'b1)
         chk({24'h0, src_accum_overflow_flag_reg, word_result_reg},
            word_q.size() > 0 ? word_q.pop_front() : 'x);
      if (acc_second_we_reg === 1'b1)
         chk({carry_flag_reg, acc_second_result_reg},
            sec_q.size() > 0 ? sec_q.pop_front() : 'x);
      if (temp3_we_reg === 1'b1)
         chk({25'h0, temp_register_three_reg},
            t3_q.size() > 0 ? t3_q.pop_front() : 'x);
   end
   initial begin
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      // random back-to-back shifts: acc right, reg right, reg left
      for (int i = 0; i < 24; i++) begin
         rng = xs(rng);
         s = {rng[7:0], xs(rng)};
         a = rng[31:16];
         m = {rng[0], 7'h40};
         if (i < 8)
            t(SSD_OP_SHIFT_RIGHT, 3'd4, m, s, '0, a, '0,
               {1'b0, m[7] & s[39], s[39:1]});
         else if (i < 16)
            t(SSD_OP_SHIFT_RIGHT, '0, '0, s, '0, a, '0,
               {25'h0, a[15], a[15:1]});
         else
            t(SSD_OP_SHIFT_LEFT, '0, '0, s, '0, a, '0,
               {24'h0, a[15] ^ a[14], a[14:0], 1'b0});
      end
      // saturation boundaries of both shifters
      t(SSD_OP_SHIFT_LEFT, '0, 8'h10, '0, '0, 16'hEF27, '0,
         41'h0DE4E);
      t(SSD_OP_SHIFT_LEFT, '0, 8'h10, '0, '0, 16'h4000, '0,
         41'h17FFF);
      t(SSD_OP_SHIFT_LEFT, '0, 8'h10, '0, '0, 16'h8000, '0,
         41'h18000);
      t(SSD_OP_SHIFT_LEFT, 3'd4, 8'h20, 40'h40000000, '0, '0, '0,
         41'h1007FFFFFFF);
      t(SSD_OP_SHIFT_LEFT, 3'd4, 8'hA0, 40'hFF80000000, '0, '0, '0,
         41'h1FF80000000);
      t(SSD_OP_SHIFT_LEFT, 3'd4, 8'h60, 40'h4000000000, '0, '0, '0,
         41'h17FFFFFFFFF);
      t(SSD_OP_SHIFT_LEFT, 3'd4, 8'h60, 40'h8000000001, '0, '0, '0,
         41'h18000000000);
      t(SSD_OP_SHIFT_LEFT, 3'd4, 8'h28, 40'h4000000000, '0, '0, '0,
         41'h08000000000);
      // square and accumulate: plain, fractional, rounded, saturated
      t(SSD_OP_SQA_REG, '0, '0, 40'h20000, 40'h5, '0, '0, 41'h9);
      t(SSD_OP_SQA_REG, '0, 8'h04, 40'h20000, 40'h5, '0, '0, 41'hD);
      t(SSD_OP_SQA_REG, 3'd2, '0, 40'h20000, 40'h9000, '0, '0,
         41'h10000);
      t(SSD_OP_SQA_REG, '0, 8'h20, 40'h20000, 40'h7FFFFFFF, '0, '0,
         41'h1007FFFFFFF);
      t(SSD_OP_SQA_MEM, 3'd1, '0, 40'h3, '0, '0, 16'hFFFE, 41'h7);
      t3_q.push_back(41'h0FFFE);
      t(SSD_OP_SQA_MEM, '0, 8'h06, '0, '0, '0, 16'h8000,
         41'h0007FFFFFFF);
      t(SSD_OP_SQA_MEM, '0, 8'h04, '0, '0, '0, 16'h8000,
         41'h0FF80000000);
      // square distance, with and without a borrow
      u_dec.issue(SSD_OP_SQUARE_DISTANCE, '0, 8'h80, 40'hFFABCD0000, '0, '0,
         16'h0055, 16'h00AA);
      acc_q.push_back(41'h0001BB18229);
      sec_q.push_back(41'h0FFFFAB0000);
      u_dec.issue(SSD_OP_SQUARE_DISTANCE, '0, 8'h80, 40'hFFABCD0000, '0, '0,
         16'h00AA, 16'h0055);
      acc_q.push_back(41'h0001BB18229);
      sec_q.push_back(41'h10000550000);
      u_dec.idle();
      // bounded drain; leftovers count as a mismatch
      for (int i = 0; i < 20; i++)
         if (acc_q.size() + word_q.size() + sec_q.size() + t3_q.size() > 0)
            @(negedge ref_clk);
      chk(41'(acc_q.size() + word_q.size() + sec_q.size() + t3_q.size()),
         '0);
      close_out();
   end
endmodule
